// ---- src/plcagc_regs.sv ----
// PHY status flags and gain-control register bank
// Contract
// - Checksum flag high when CRC16 passed
// - Attenuation flag follows gain direction when enabled
// - Attenuation flag reads zero when disabled
// - FEC flag high while buffer holds frame
// - Unstarted frame waits; next frame locks
// - Receive reset clears the lockup
// - Forget factor resets 007Ch, read/write
// - Desired energy resets 00F0h, read/write
// - Window length resets 00FFh
// - Window length sets gain update interval
// - Status register writes change nothing
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module plcagc_regs (
  // Clock, reset, enable
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  // Receive path pins (asynchronous)
  input wire logic frame_done,
  input wire logic frame_crc_ok,
  input wire logic fec_loaded,
  input wire logic fec_drained,
  input wire logic gain_attenuating,
  // Gain control outputs
  output logic [15:0] forget_factor_field,
  output logic [15:0] desired_energy_field,
  output logic [15:0] window_length_field,
  output logic agc_enable,
  output logic gain_update,
  // Receive control outputs
  output logic frame_start_bit,
  output logic rx_locked,
  // Interrupt
  output logic irq
);
  // Input synchronisers
  logic [4:0] sync1_reg;
  logic [4:0] sync2_reg;
  logic done_d_reg;
  logic drained_d_reg;
  logic done_rise;
  logic drained_rise;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sync1_reg <= 5'h00;
      sync2_reg <= 5'h00;
      done_d_reg <= 1'b0;
      drained_d_reg <= 1'b0;
    end else if (ce) begin
      sync1_reg <= {gain_attenuating, fec_drained, fec_loaded, frame_crc_ok, frame_done};
      sync2_reg <= sync1_reg;
      done_d_reg <= sync2_reg[0];
      drained_d_reg <= sync2_reg[3];
    end
  end
  assign done_rise = sync2_reg[0] && !done_d_reg;
  assign drained_rise = sync2_reg[3] && !drained_d_reg;

  // Register state
  logic [15:0] ffac_reg;
  logic [15:0] ffac_next;
  logic [15:0] denergy_reg;
  logic [15:0] denergy_next;
  logic [15:0] winlen_reg;
  logic [15:0] winlen_next;
  logic [2:0] ctl_reg;
  logic [2:0] ctl_next;
  logic [2:0] ist_reg;
  logic [2:0] ist_next;
  logic [2:0] imsk_reg;
  logic [2:0] imsk_next;
  // Status flag state
  logic crc_reg;
  logic crc_next;
  logic fec_reg;
  logic fec_next;
  logic att_reg;
  logic att_next;
  // Read data and receive state
  logic [15:0] rdata_next;
  plcagc_pkg::plcagc_rx_e rx_reg;
  plcagc_pkg::plcagc_rx_e rx_next;
  // Decoded write strobes
  logic wr_ffac;
  logic wr_denergy;
  logic wr_winlen;
  logic wr_ctl;
  logic wr_ist;
  logic wr_imsk;
  // Control pulses and helpers
  logic rx_reset;
  logic start_req;
  logic [15:0] status_val;
  logic [2:0] ev;
  logic win_tick;

  assign wr_ffac = wr && (addr == plcagc_pkg::FFAC_IDX);
  assign wr_denergy = wr && (addr == plcagc_pkg::DENERGY_IDX);
  assign wr_winlen = wr && (addr == plcagc_pkg::WINLEN_IDX);
  assign wr_ctl = wr && (addr == plcagc_pkg::CTL_IDX);
  assign wr_ist = wr && (addr == plcagc_pkg::IST_IDX);
  assign wr_imsk = wr && (addr == plcagc_pkg::IMSK_IDX);
  assign rx_reset = wr_ctl && wdata[plcagc_pkg::CTL_RXRST_BIT];
  assign start_req = wr_ctl && wdata[plcagc_pkg::CTL_START_BIT];

  // Configuration registers
  always_comb begin
    ffac_next = wr_ffac ? wdata : ffac_reg;
    denergy_next = wr_denergy ? wdata : denergy_reg;
    winlen_next = wr_winlen ? wdata : winlen_reg;
    imsk_next = wr_imsk ? wdata[2:0] : imsk_reg;
    // Enable bit holds its value between writes
    ctl_next = {1'b0, 1'b0, ctl_reg[plcagc_pkg::CTL_AGC_EN_BIT]};
    if (wr_ctl) begin
      ctl_next[plcagc_pkg::CTL_AGC_EN_BIT] = wdata[plcagc_pkg::CTL_AGC_EN_BIT];
    end
    // Start and receive reset are one-cycle pulses
    ctl_next[plcagc_pkg::CTL_START_BIT] = start_req;
    ctl_next[plcagc_pkg::CTL_RXRST_BIT] = rx_reset;
  end

  // Status flags
  always_comb begin
    crc_next = crc_reg;
    fec_next = fec_reg;
    if (done_rise) begin
      crc_next = sync2_reg[1];
    end
    // buffer occupancy flag
    // Occupied level beats a drain edge in the same cycle
    if (sync2_reg[2]) begin
      fec_next = 1'b1;
    end else if (drained_rise) begin
      fec_next = 1'b0;
    end
    // receive reset drops stale frame flags
    if (rx_reset) begin
      fec_next = 1'b0;
      crc_next = 1'b0;
    end
    att_next = ctl_reg[plcagc_pkg::CTL_AGC_EN_BIT] ? sync2_reg[4] : 1'b0;
  end

  // Receive handshake
  always_comb begin
    rx_next = rx_reg;
    ev = 3'h0;
    case (rx_reg)
      plcagc_pkg::PLCAGC_IDLE: begin
        if (done_rise) begin
          rx_next = plcagc_pkg::PLCAGC_WAIT;
          ev[plcagc_pkg::IRQ_RXDONE_BIT] = 1'b1;
        end
      end
      // wait for start, second frame locks
      plcagc_pkg::PLCAGC_WAIT: begin
        if (start_req) begin
          rx_next = plcagc_pkg::PLCAGC_IDLE;
        end else if (done_rise) begin
          rx_next = plcagc_pkg::PLCAGC_LOCK;
          ev[plcagc_pkg::IRQ_LOCK_BIT] = 1'b1;
        end
      end
      plcagc_pkg::PLCAGC_LOCK: begin
        rx_next = plcagc_pkg::PLCAGC_LOCK;
      end
      default: begin
        rx_next = plcagc_pkg::PLCAGC_IDLE;
      end
    endcase
    if (rx_reset) begin
      rx_next = plcagc_pkg::PLCAGC_IDLE;
    end
    ev[plcagc_pkg::IRQ_UPD_BIT] = win_tick;
  end

  // Interrupt status
  always_comb begin
    // Sticky status: set wins over write-one clear
    ist_next = ist_reg;
    if (wr_ist) begin
      ist_next = ist_reg & ~wdata[2:0];
    end
    ist_next = ist_next | ev;
  end

  plcagc_win u_win (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .run(ctl_reg[plcagc_pkg::CTL_AGC_EN_BIT]),
    .length(winlen_reg),
    .tick(win_tick)
  );

  always_comb begin
    status_val = plcagc_pkg::STATUS_RST;
    status_val[plcagc_pkg::CRC_BIT] = crc_reg;
    status_val[plcagc_pkg::ATT_BIT] = att_reg;
    status_val[plcagc_pkg::FEC_BIT] = fec_reg;
    // Read data returns to zero when no read is pending
    rdata_next = plcagc_pkg::ZERO16;
    if (rd) begin
      case (addr)
        plcagc_pkg::STATUS_IDX: rdata_next = status_val;
        plcagc_pkg::FFAC_IDX: rdata_next = ffac_reg;
        plcagc_pkg::DENERGY_IDX: rdata_next = denergy_reg;
        plcagc_pkg::WINLEN_IDX: rdata_next = winlen_reg;
        plcagc_pkg::CTL_IDX: rdata_next = {13'h0000, ctl_reg};
        plcagc_pkg::IST_IDX: rdata_next = {13'h0000, ist_reg};
        plcagc_pkg::IMSK_IDX: rdata_next = {13'h0000, imsk_reg};
        default: rdata_next = plcagc_pkg::ZERO16;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ffac_reg <= plcagc_pkg::FFAC_RST;
      denergy_reg <= plcagc_pkg::DENERGY_RST;
      winlen_reg <= plcagc_pkg::WINLEN_RST;
      ctl_reg <= plcagc_pkg::CTL_RST;
      ist_reg <= plcagc_pkg::IRQ_RST;
      imsk_reg <= plcagc_pkg::IRQ_RST;
      crc_reg <= 1'b0;
      fec_reg <= 1'b0;
      att_reg <= 1'b0;
      rx_reg <= plcagc_pkg::PLCAGC_IDLE;
      rdata <= plcagc_pkg::ZERO16;
    end else if (ce) begin
      ffac_reg <= ffac_next;
      denergy_reg <= denergy_next;
      winlen_reg <= winlen_next;
      ctl_reg <= ctl_next;
      ist_reg <= ist_next;
      imsk_reg <= imsk_next;
      crc_reg <= crc_next;
      fec_reg <= fec_next;
      att_reg <= att_next;
      rx_reg <= rx_next;
      rdata <= rdata_next;
    end
  end

  // Field copies for the gain-control datapath
  assign forget_factor_field = ffac_reg;
  assign desired_energy_field = denergy_reg;
  assign window_length_field = winlen_reg;
  // Control and receive state outputs
  assign agc_enable = ctl_reg[plcagc_pkg::CTL_AGC_EN_BIT];
  assign gain_update = win_tick;
  assign frame_start_bit = ctl_reg[plcagc_pkg::CTL_START_BIT];
  assign rx_locked = (rx_reg == plcagc_pkg::PLCAGC_LOCK);
  assign irq = |(ist_reg & imsk_reg);
endmodule // plcagc_regs
`default_nettype wire

// ---- include/plcagc_pkg.sv ----
// Package: register map, field positions and reset values of the PHY status and gain-control registers
package plcagc_pkg;
  // Register offsets (word indices, not byte addresses: byte address is four times the index)
  localparam logic [7:0] STATUS_IDX = 8'h05;
  localparam logic [7:0] FFAC_IDX = 8'h07;
  localparam logic [7:0] DENERGY_IDX = 8'h08;
  localparam logic [7:0] WINLEN_IDX = 8'h09;
  localparam logic [7:0] CTL_IDX = 8'h10;
  localparam logic [7:0] IST_IDX = 8'h11;
  localparam logic [7:0] IMSK_IDX = 8'h12;
  // Status bit positions
  localparam int CRC_BIT = 7;
  localparam int ATT_BIT = 8;
  localparam int FEC_BIT = 9;
  // Control bit positions
  localparam int CTL_AGC_EN_BIT = 0;
  localparam int CTL_START_BIT = 1;
  localparam int CTL_RXRST_BIT = 2;
  // Interrupt status bit positions
  localparam int IRQ_RXDONE_BIT = 0;
  localparam int IRQ_LOCK_BIT = 1;
  localparam int IRQ_UPD_BIT = 2;
  // Reset values
  localparam logic [15:0] FFAC_RST = 16'h007c;
  localparam logic [15:0] DENERGY_RST = 16'h00f0;
  localparam logic [15:0] WINLEN_RST = 16'h00ff;
  localparam logic [15:0] STATUS_RST = 16'h0000;
  localparam logic [15:0] ZERO16 = 16'h0000;
  localparam logic [2:0] CTL_RST = 3'h0;
  localparam logic [2:0] IRQ_RST = 3'h0;
  // Receive states
  typedef enum logic [1:0] {PLCAGC_IDLE, PLCAGC_WAIT, PLCAGC_LOCK} plcagc_rx_e;
endpackage

// ---- src/plcagc_win.sv ----
// Window interval counter for gain updates
`timescale 1ns/1ns
`default_nettype none
module plcagc_win (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  // Control
  input wire logic run,
  input wire logic [15:0] length,
  // Pulse when a window ends
  output logic tick
);
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic tick_next;
  always_comb begin
    cnt_next = cnt_reg;
    tick_next = 1'b0;
    if (!run) begin
      cnt_next = plcagc_pkg::ZERO16;
    end else if (cnt_reg >= length) begin
      cnt_next = plcagc_pkg::ZERO16;
      tick_next = 1'b1;
    end else begin
      cnt_next = cnt_reg + 16'h0001;
    end
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_reg <= plcagc_pkg::ZERO16;
      tick <= 1'b0;
    end else if (ce) begin
      cnt_reg <= cnt_next;
      tick <= tick_next;
    end
  end
endmodule // plcagc_win
`default_nettype wire

// ---- verif/plcagc_regs_chk.sv ----
// Assertion checker for the PHY status and gain-control registers
`timescale 1ns/1ns
`default_nettype none
module plcagc_regs_chk (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Register port
  input wire logic ce,
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [15:0] rdata,
  // Gain and receive control
  input wire logic [15:0] forget_factor_field,
  input wire logic [15:0] desired_energy_field,
  input wire logic [15:0] window_length_field,
  input wire logic agc_enable,
  input wire logic gain_update,
  input wire logic frame_start_bit,
  input wire logic rx_locked
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  sequence s_rd(logic [7:0] a);
    rd && ce && addr == a;
  endsequence
  sequence s_wr(logic [7:0] a);
    wr && ce && addr == a;
  endsequence
  property p_ff_rd;
    s_rd(plcagc_pkg::FFAC_IDX) |=> rdata == $past(forget_factor_field);
  endproperty
  a_ff_rd: assert property (p_ff_rd) else $error("forget factor readback wrong");
  property p_de_wr;
    s_wr(plcagc_pkg::DENERGY_IDX) |=> desired_energy_field == $past(wdata);
  endproperty
  a_de_wr: assert property (p_de_wr) else $error("desired energy not written");
  property p_wl_rd;
    s_rd(plcagc_pkg::WINLEN_IDX) |=> rdata == $past(window_length_field);
  endproperty
  a_wl_rd: assert property (p_wl_rd) else $error("window length readback wrong");
  property p_rst_val;
    $fell(rst) |-> forget_factor_field == plcagc_pkg::FFAC_RST && desired_energy_field == plcagc_pkg::DENERGY_RST
      && window_length_field == plcagc_pkg::WINLEN_RST;
  endproperty
  a_rst_val: assert property (p_rst_val) else $error("reset values wrong");
  property p_rsv;
    s_rd(plcagc_pkg::STATUS_IDX) |=> rdata[15:10] == 6'h00 && rdata[6:0] == 7'h00;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved status bits set");
  property p_att_off;
    s_rd(plcagc_pkg::STATUS_IDX) && !agc_enable && !$past(agc_enable) |=> !rdata[plcagc_pkg::ATT_BIT];
  endproperty
  a_att_off: assert property (p_att_off) else $error("attenuation flag set while disabled");
  property p_start;
    s_wr(plcagc_pkg::CTL_IDX) && wdata[plcagc_pkg::CTL_START_BIT] |-> ##[1:2] frame_start_bit ##1 !frame_start_bit;
  endproperty
  a_start: assert property (p_start) else $error("start pulse missing");
  property p_rxrst;
    s_wr(plcagc_pkg::CTL_IDX) && wdata[plcagc_pkg::CTL_RXRST_BIT] |-> ##[1:2] !rx_locked;
  endproperty
  a_rxrst: assert property (p_rxrst) else $error("lockup not cleared");
  property p_noupd;
    !agc_enable [*3] |-> !gain_update;
  endproperty
  a_noupd: assert property (p_noupd) else $error("gain update while disabled");
  property p_win;
    gain_update && agc_enable && window_length_field == 16'h0003 |=> !gain_update [*3] ##1 gain_update;
  endproperty
  a_win: assert property (p_win) else $error("gain update interval wrong");
endmodule // plcagc_regs_chk
bind plcagc_regs plcagc_regs_chk plcagc_regs_chk_i (.clock, .rst, .ce, .addr, .wdata, .wr, .rd, .rdata,
  .forget_factor_field, .desired_energy_field, .window_length_field, .agc_enable, .gain_update,
  .frame_start_bit, .rx_locked);
`default_nettype wire

// ---- verif/testbench.sv ----
// Self-checking bench for the PHY status and gain-control registers
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clock, rst, ce, wr, rd, frame_done, frame_crc_ok, fec_loaded, fec_drained, gain_attenuating;
  logic agc_enable, gain_update, frame_start_bit, rx_locked, irq;
  logic [7:0] addr;
  logic [15:0] wdata, rdata, forget_factor_field, desired_energy_field, window_length_field;
  logic [31:0] seed = 32'h4ec6e23a;
  int error_cnt = 0;
  int cmp_count = 0;
  int n;
  plcagc_regs plcagc_regs_i (.clock, .rst, .ce, .addr, .wdata, .wr, .rd, .rdata, .frame_done, .frame_crc_ok,
    .fec_loaded, .fec_drained, .gain_attenuating, .forget_factor_field, .desired_energy_field,
    .window_length_field, .agc_enable, .gain_update, .frame_start_bit, .rx_locked, .irq);
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [15:0] status_word(input logic c, input logic t, input logic f);
    return {6'h00, f, t, c, 7'h00};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rreg(input logic [7:0] a, input logic [15:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 chk(rdata, e);
    @(posedge clock);
  endtask
  task automatic frame(input logic c);
    frame_crc_ok <= c;
    frame_done <= 1'b1;
    repeat (3) @(posedge clock);
    frame_done <= 1'b0;
    repeat (6) @(posedge clock);
  endtask
  task automatic complete_run;
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    {rst, ce, wr, rd, frame_done, frame_crc_ok, fec_loaded, fec_drained, gain_attenuating} = 9'h180;
    addr = 8'h00;
    wdata = 16'h0000;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    rreg(plcagc_pkg::FFAC_IDX, plcagc_pkg::FFAC_RST);
    rreg(plcagc_pkg::DENERGY_IDX, plcagc_pkg::DENERGY_RST);
    rreg(plcagc_pkg::WINLEN_IDX, plcagc_pkg::WINLEN_RST);
    for (n = 0; n < 12; n++) begin
      seed = lfsr(seed);
      wreg(plcagc_pkg::FFAC_IDX + 8'(n % 3), seed[15:0]);
      rreg(plcagc_pkg::FFAC_IDX + 8'(n % 3), seed[15:0]);
    end
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    rreg(plcagc_pkg::FFAC_IDX, plcagc_pkg::FFAC_RST);
    wreg(plcagc_pkg::STATUS_IDX, 16'hffff);
    rreg(plcagc_pkg::STATUS_IDX, status_word(0, 0, 0));
    rreg(8'h3f, 16'h0000);
    gain_attenuating <= 1'b1;
    fec_loaded <= 1'b1;
    frame(1'b1);
    rreg(plcagc_pkg::STATUS_IDX, status_word(1, 0, 1));
    chk({15'h0, irq}, 16'h0000);
    wreg(plcagc_pkg::IMSK_IDX, 16'h0001);
    chk({15'h0, irq}, 16'h0001);
    wreg(plcagc_pkg::IST_IDX, 16'h0001);
    chk({15'h0, irq}, 16'h0000);
    wreg(plcagc_pkg::CTL_IDX, 16'h0001);
    rreg(plcagc_pkg::STATUS_IDX, status_word(1, 1, 1));
    gain_attenuating <= 1'b0;
    fec_loaded <= 1'b0;
    fec_drained <= 1'b1;
    repeat (4) @(posedge clock);
    fec_drained <= 1'b0;
    rreg(plcagc_pkg::STATUS_IDX, status_word(1, 0, 0));
    wreg(plcagc_pkg::CTL_IDX, 16'h0003);
    frame(1'b0);
    chk({15'h0, rx_locked}, 16'h0000);
    rreg(plcagc_pkg::STATUS_IDX, status_word(0, 0, 0));
    frame(1'b1);
    chk({15'h0, rx_locked}, 16'h0001);
    wreg(plcagc_pkg::CTL_IDX, 16'h0005);
    chk({15'h0, rx_locked}, 16'h0000);
    rreg(plcagc_pkg::STATUS_IDX, status_word(0, 0, 0));
    wreg(plcagc_pkg::CTL_IDX, 16'h0000);
    repeat (8) @(posedge clock);
    wreg(plcagc_pkg::WINLEN_IDX, 16'h0003);
    wreg(plcagc_pkg::CTL_IDX, 16'h0001);
    n = 0;
    repeat (40) @(negedge clock) n += int'(gain_update);
    chk(16'(n), 16'd10);
    complete_run;
  end
endmodule // testbench
`default_nettype wire
